// ---- cpwd_pkg.sv ----
// constants, types and register map of the clock and watchdog supervisor
// assumes an ahb-lite slave with 32-bit words and one 50 MHz clock
package cpwd_pkg;
	// printed offsets are not multiples of four: kept as indices
	localparam logic [7:0] CPWD_IDX_TRIM_HI = 8'h18;
	localparam logic [7:0] CPWD_IDX_TRIM_LO = 8'h19;
	localparam logic [7:0] CPWD_IDX_CTRL = 8'h20;
	localparam logic [7:0] CPWD_IDX_DIV = 8'h21;
	localparam logic [7:0] CPWD_IDX_STAT = 8'h22;
	localparam logic [7:0] CPWD_IDX_IRQ = 8'h23;
	localparam logic [7:0] CPWD_IDX_MASK = 8'h24;
	localparam logic [7:0] CPWD_IDX_WDSVC = 8'h25;
	localparam logic [7:0] CPWD_IDX_WDCFG = 8'h26;
	// ctrl bit positions
	localparam int CPWD_C_WRITE_PROTECT = 0;
	localparam int CPWD_C_LOOPSEL = 1;
	localparam int CPWD_C_LOCK_IRQ_ENABLE = 2;
	localparam int CPWD_C_OSC_ENABLE = 3;
	localparam int CPWD_C_PSEUDO_STOP = 4;
	localparam int CPWD_C_PCE = 5;
	localparam int CPWD_C_STOP_AUTOCLOCK_DISABLE = 6;
	localparam int CPWD_C_WDSEL0 = 7;
	localparam int CPWD_C_WDSEL1 = 8;
	// status / irq bit positions
	localparam int CPWD_S_LOCK = 0;
	localparam int CPWD_S_OSC_STABLE = 1;
	localparam int CPWD_I_LOCK = 0;
	localparam int CPWD_I_MON = 1;
	localparam int CPWD_I_WD = 2;
	localparam logic [31:0] CPWD_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CPWD_DIV_RST = 32'h0000_0018;
	localparam logic [15:0] CPWD_WSVC_KEY1 = 16'h0055;
	localparam logic [15:0] CPWD_WSVC_KEY2 = 16'h00AA;
	localparam logic [15:0] CPWD_LOCK_TOL = 16'h0002;
	localparam logic [15:0] CPWD_UNL_TOL = 16'h0004;
	localparam logic [7:0] CPWD_OSC_SETTLE = 8'h40;
	localparam logic [7:0] CPWD_MON_WIN = 8'h80;
	localparam logic [7:0] CPWD_MON_MIN = 8'h02;
	localparam logic [2:0] CPWD_RESYNC = 3'h3;
	typedef enum logic [1:0] {
		CPWD_S_IDLE = 2'b00,
		CPWD_S_ADDR = 2'b01,
		CPWD_S_DATA = 2'b11
	} cpwd_bus_t;
endpackage

// ---- cpwd_lock_if.sv ----
// lock detector handshake between the top and the lock-window counter
// one clock domain, all sampled edges already synchronised
`timescale 1ns/1ns
interface cpwd_lock_if;
	logic ref_tick;
	logic fb_tick;
	logic clear;
	logic locked;
	modport top (output ref_tick, output fb_tick, output clear, input locked);
	modport det (input ref_tick, input fb_tick, input clear, output locked);
endinterface

// ---- cpwd_lock_det.sv ----
// frequency comparator: counts feedback ticks over a window of reference ticks
// ticks are one-cycle pulses on clk
`timescale 1ns/1ns
module cpwd_lock_det
	import cpwd_pkg::*;
#(
	parameter int WIN = 16
)
(
	input wire logic clk, // system clock
	input wire logic rstn, // async reset, low
	cpwd_lock_if.det lk // tick and lock handshake
);
	logic [15:0] ref_cnt_r, ref_cnt_nxt;
	logic [15:0] fb_cnt_r, fb_cnt_nxt;
	logic [15:0] idle_r, idle_nxt;
	logic locked_r, locked_nxt;
	logic [15:0] diff;

	always_comb
	begin
		ref_cnt_nxt = ref_cnt_r;
		fb_cnt_nxt = fb_cnt_r;
		idle_nxt = idle_r + 16'h0001;
		locked_nxt = locked_r;
		diff = (fb_cnt_r > 16'(WIN)) ? fb_cnt_r - 16'(WIN) : 16'(WIN) - fb_cnt_r;
		if (lk.fb_tick)
			fb_cnt_nxt = fb_cnt_r + 16'h0001;
		if (lk.ref_tick)
		begin
			idle_nxt = 16'h0000;
			ref_cnt_nxt = ref_cnt_r + 16'h0001;
			if (ref_cnt_r == 16'(WIN - 1))
			begin
				ref_cnt_nxt = 16'h0000;
				fb_cnt_nxt = {15'h0000, lk.fb_tick};
				// hysteresis: tight band to lock, wider band to unlock
				if (diff <= CPWD_LOCK_TOL)
					locked_nxt = 1'b1;
				else if (diff > CPWD_UNL_TOL)
					locked_nxt = 1'b0;
			end
		end
		// a silent reference is a lost reference
		if (idle_r == 16'hFFFF)
		begin
			locked_nxt = 1'b0;
			idle_nxt = idle_r;
		end
		if (lk.clear)
		begin
			locked_nxt = 1'b0;
			ref_cnt_nxt = 16'h0000;
			fb_cnt_nxt = 16'h0000;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ref_cnt_r <= 16'h0000;
			fb_cnt_r <= 16'h0000;
			idle_r <= 16'h0000;
			locked_r <= 1'b0;
		end
		else
		begin
			ref_cnt_r <= ref_cnt_nxt;
			fb_cnt_r <= fb_cnt_nxt;
			idle_r <= idle_nxt;
			locked_r <= locked_nxt;
		end
	end

	assign lk.locked = locked_r;
endmodule // cpwd_lock_det

// ---- cpwd_top.sv ----
// clock supervisor: rc trim, pll dividers, lock detect, pll monitor, watchdog
// analog clocks arrive as async pins and are sampled on clk before use
`timescale 1ns/1ns
module cpwd_top
	import cpwd_pkg::*;
#(
	parameter int WD_BITS = 16, // watchdog timeout is 2**WD_BITS source ticks
	parameter int LOCK_WIN = 16 // reference ticks per lock comparison
)
(
	input wire logic clk, // 50 MHz bus clock
	input wire logic rstn, // async reset, low
	input wire logic [31:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write
	input wire logic [2:0] hsize, // ahb size
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hsel, // ahb select
	input wire logic hready, // ahb bus ready
	output logic [31:0] hrdata, // ahb read data
	output logic hreadyout, // ahb slave ready
	output logic hresp, // ahb response, always okay
	input wire logic [15:0] factory_trim, // trim word from flash
	input wire logic trim_load_valid, // flash trim word present
	input wire logic vco_clock, // vco output pin
	input wire logic ref_src_rc, // internal_rc_clock pin
	input wire logic crystal_clock, // crystal oscillator pin
	input wire logic auto_clock, // autonomous clock pin
	input wire logic stop_mode, // device in stop
	output logic [15:0] rc_trim, // trim to rc oscillator
	output logic pll_enable, // pll powered
	output logic [1:0] ref_range, // loop bandwidth ref range
	output logic [1:0] vco_range, // loop bandwidth vco range
	output logic pll_clock, // vco over post divider
	output logic bus_clock_div, // half of pll_clock
	output logic monitor_reset, // pll clock monitor reset pulse
	output logic watchdog_reset, // watchdog timeout reset pulse
	output logic irq // level interrupt
);
	// two-flop sync of all asynchronous clocks: vco, rc, xtal, aclk
	logic [3:0] s1_r, s2_r, s3_r;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_r <= 4'h0;
			s2_r <= 4'h0;
			s3_r <= 4'h0;
		end
		else
		begin
			s1_r <= {auto_clock, crystal_clock, ref_src_rc, vco_clock};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	logic [3:0] rise;
	assign rise = s2_r & ~s3_r;

	// ahb-lite slave
	cpwd_bus_t bst_r, bst_nxt;
	logic [7:0] idx_r, idx_nxt;
	logic wr_r, wr_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic [15:0] trim_r, trim_nxt;
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [31:0] div_r, div_nxt;
	logic [2:0] irqs_r, irqs_nxt;
	logic [2:0] mask_r, mask_nxt;
	logic osc_stable_r, osc_stable_nxt;
	logic [7:0] osc_cnt_r, osc_cnt_nxt;
	logic loaded_r, loaded_nxt;
	logic wd_svc_r, wd_svc_nxt;
	logic [15:0] wd_last_r, wd_last_nxt;
	logic trim_wr, trim_clear;
	logic lock_now, lock_q_r;
	logic mon_fire, wd_fire, irq_r, irq_nxt, pll_en_r, pll_en_nxt;

	assign trim_wr = wr_r && bst_r == CPWD_S_DATA && !ctrl_r[CPWD_C_WRITE_PROTECT] &&
		(idx_r == CPWD_IDX_TRIM_HI || idx_r == CPWD_IDX_TRIM_LO);
	assign trim_clear = trim_wr && ctrl_r[CPWD_C_LOOPSEL];

	always_comb
	begin
		bst_nxt = CPWD_S_IDLE;
		idx_nxt = idx_r;
		wr_nxt = 1'b0;
		rd_nxt = rd_r;
		trim_nxt = trim_r;
		ctrl_nxt = ctrl_r;
		div_nxt = div_r;
		mask_nxt = mask_r;
		wd_svc_nxt = 1'b0;
		wd_last_nxt = wd_last_r;
		loaded_nxt = loaded_r;
		irqs_nxt = irqs_r;
		// factory trim lands once, after reset release
		if (!loaded_r && trim_load_valid)
		begin
			trim_nxt = factory_trim;
			loaded_nxt = 1'b1;
		end
		if (hsel && hready && htrans[1])
		begin
			bst_nxt = CPWD_S_DATA;
			idx_nxt = haddr[9:2];
			wr_nxt = hwrite;
		end
		if (bst_r == CPWD_S_DATA && wr_r)
		begin
			case (idx_r)
				CPWD_IDX_TRIM_HI:
				begin
					if (trim_wr)
						trim_nxt[15:8] = {hwdata[7:3], 1'b0, hwdata[1:0]};
				end
				CPWD_IDX_TRIM_LO:
				begin
					if (trim_wr)
						trim_nxt[7:0] = hwdata[7:0];
				end
				CPWD_IDX_CTRL: ctrl_nxt = {23'h0, hwdata[8:0]};
				CPWD_IDX_DIV: div_nxt = {13'h0, hwdata[18:0]};
				CPWD_IDX_IRQ: irqs_nxt = irqs_r & ~hwdata[2:0];
				CPWD_IDX_MASK: mask_nxt = hwdata[2:0];
				CPWD_IDX_WDSVC:
				begin
					// two-key service sequence
					wd_last_nxt = hwdata[15:0];
					wd_svc_nxt = (wd_last_r == CPWD_WSVC_KEY1) && (hwdata[15:0] == CPWD_WSVC_KEY2);
				end
				default: ;
			endcase
		end
		// set wins over a same-cycle clear
		if (lock_now != lock_q_r && ctrl_r[CPWD_C_LOCK_IRQ_ENABLE])
			irqs_nxt[CPWD_I_LOCK] = 1'b1;
		if (mon_fire)
			irqs_nxt[CPWD_I_MON] = 1'b1;
		if (wd_fire)
			irqs_nxt[CPWD_I_WD] = 1'b1;
		rd_nxt = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite)
		begin
			case (haddr[9:2])
				CPWD_IDX_TRIM_HI: rd_nxt = {24'h0, trim_r[15:11], 1'b0, trim_r[9:8]};
				CPWD_IDX_TRIM_LO: rd_nxt = {24'h0, trim_r[7:0]};
				CPWD_IDX_CTRL: rd_nxt = ctrl_r;
				CPWD_IDX_DIV: rd_nxt = div_r;
				CPWD_IDX_STAT: rd_nxt = {30'h0, osc_stable_r, lock_now};
				CPWD_IDX_IRQ: rd_nxt = {29'h0, irqs_r};
				CPWD_IDX_MASK: rd_nxt = {29'h0, mask_r};
				default: rd_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bst_r <= CPWD_S_IDLE;
			idx_r <= 8'h00;
			wr_r <= 1'b0;
			rd_r <= 32'h0000_0000;
			trim_r <= 16'h0000;
			ctrl_r <= CPWD_CTRL_RST;
			div_r <= CPWD_DIV_RST;
			irqs_r <= 3'h0;
			mask_r <= 3'h0;
			loaded_r <= 1'b0;
			wd_svc_r <= 1'b0;
			wd_last_r <= 16'h0000;
		end
		else
		begin
			bst_r <= bst_nxt;
			idx_r <= idx_nxt;
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			trim_r <= trim_nxt;
			ctrl_r <= ctrl_nxt;
			div_r <= div_nxt;
			irqs_r <= irqs_nxt;
			mask_r <= mask_nxt;
			loaded_r <= loaded_nxt;
			wd_svc_r <= wd_svc_nxt;
			wd_last_r <= wd_last_nxt;
		end
	end

	// div fields: [5:0] feedback, [9:6] reference, [14:10] post, [16:15] ref range,
	// [18:17] vco range
	logic [5:0] fb_cnt_r, fb_cnt_nxt;
	logic [3:0] rf_cnt_r, rf_cnt_nxt;
	logic [4:0] pd_cnt_r, pd_cnt_nxt;
	logic fb_tick_r, fb_tick_nxt, rf_tick_r, rf_tick_nxt;
	logic pll_r, pll_nxt, bus_r, bus_nxt;
	logic full_stop, ref_edge;
	assign full_stop = stop_mode && !ctrl_r[CPWD_C_PSEUDO_STOP];
	assign ref_edge = ctrl_r[CPWD_C_OSC_ENABLE] ? rise[2] : rise[1];

	always_comb
	begin
		fb_cnt_nxt = fb_cnt_r;
		rf_cnt_nxt = rf_cnt_r;
		pd_cnt_nxt = pd_cnt_r;
		fb_tick_nxt = 1'b0;
		rf_tick_nxt = 1'b0;
		pll_nxt = pll_r;
		bus_nxt = bus_r;
		if (rise[0])
		begin
			fb_cnt_nxt = fb_cnt_r + 6'h01;
			if (fb_cnt_r == div_r[5:0])
			begin
				fb_cnt_nxt = 6'h00;
				fb_tick_nxt = 1'b1;
			end
			pd_cnt_nxt = pd_cnt_r + 5'h01;
			if (pd_cnt_r == div_r[14:10])
			begin
				pd_cnt_nxt = 5'h00;
				pll_nxt = ~pll_r;
				if (!pll_r)
					bus_nxt = ~bus_r;
			end
		end
		if (ref_edge)
		begin
			rf_cnt_nxt = rf_cnt_r + 4'h1;
			if (rf_cnt_r == div_r[9:6])
			begin
				rf_cnt_nxt = 4'h0;
				rf_tick_nxt = 1'b1;
			end
		end
		if (full_stop)
		begin
			fb_tick_nxt = 1'b0;
			rf_tick_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			fb_cnt_r <= 6'h00;
			rf_cnt_r <= 4'h0;
			pd_cnt_r <= 5'h00;
			fb_tick_r <= 1'b0;
			rf_tick_r <= 1'b0;
			pll_r <= 1'b0;
			bus_r <= 1'b0;
		end
		else
		begin
			fb_cnt_r <= fb_cnt_nxt;
			rf_cnt_r <= rf_cnt_nxt;
			pd_cnt_r <= pd_cnt_nxt;
			fb_tick_r <= fb_tick_nxt;
			rf_tick_r <= rf_tick_nxt;
			pll_r <= pll_nxt;
			bus_r <= bus_nxt;
		end
	end

	cpwd_lock_if lk_if ();
	assign lk_if.ref_tick = rf_tick_r;
	assign lk_if.fb_tick = fb_tick_r;
	assign lk_if.clear = trim_clear || full_stop;
	assign lock_now = lk_if.locked;
	cpwd_lock_det #(.WIN(LOCK_WIN)) u_lock (.clk(clk), .rstn(rstn), .lk(lk_if));

	// oscillator stable, pll clock monitor, watchdog
	logic [7:0] mon_win_r, mon_win_nxt, mon_edges_r, mon_edges_nxt;
	logic [WD_BITS-1:0] wd_cnt_r, wd_cnt_nxt;
	logic [2:0] rsync_r, rsync_nxt;
	logic wd_src, wd_run, mon_r, mon_nxt, wdr_r, wdr_nxt;

	always_comb
	begin
		// source: sel1 -> aclk, else sel0 ? xtal : rc
		if (ctrl_r[CPWD_C_WDSEL1])
			wd_src = rise[3];
		else if (ctrl_r[CPWD_C_WDSEL0])
			wd_src = rise[2];
		else
			wd_src = rise[1];
		wd_run = 1'b1;
		if (stop_mode)
		begin
			if (ctrl_r[CPWD_C_WDSEL1])
				wd_run = !ctrl_r[CPWD_C_STOP_AUTOCLOCK_DISABLE];
			else
				wd_run = ctrl_r[CPWD_C_PSEUDO_STOP] && ctrl_r[CPWD_C_PCE] && ctrl_r[CPWD_C_WDSEL0]
					&& ctrl_r[CPWD_C_OSC_ENABLE] && osc_stable_r;
		end
	end

	assign mon_fire = mon_win_r == CPWD_MON_WIN && mon_edges_r < CPWD_MON_MIN && !full_stop;
	assign wd_fire = wd_src && wd_run && rsync_r == 3'h0 && wd_cnt_r == '1 && !wd_svc_r;

	always_comb
	begin
		osc_stable_nxt = osc_stable_r;
		osc_cnt_nxt = osc_cnt_r;
		if (!ctrl_r[CPWD_C_OSC_ENABLE])
		begin
			osc_stable_nxt = 1'b0;
			osc_cnt_nxt = 8'h00;
		end
		else if (rise[2] && osc_cnt_r != CPWD_OSC_SETTLE)
			osc_cnt_nxt = osc_cnt_r + 8'h01;
		else if (osc_cnt_r == CPWD_OSC_SETTLE)
			osc_stable_nxt = 1'b1;
		if (trim_clear)
		begin
			osc_stable_nxt = 1'b0;
			osc_cnt_nxt = 8'h00;
		end
		// monitor counts pll edges per fixed window of bus clocks
		mon_win_nxt = mon_win_r + 8'h01;
		mon_edges_nxt = mon_edges_r;
		if (pll_nxt && !pll_r && mon_edges_r != 8'hFF)
			mon_edges_nxt = mon_edges_r + 8'h01;
		if (mon_win_r == CPWD_MON_WIN || full_stop)
		begin
			mon_win_nxt = 8'h00;
			mon_edges_nxt = 8'h00;
		end
		mon_nxt = mon_fire;
		// aclk watchdog resyncs for a few ticks after leaving stop
		rsync_nxt = rsync_r;
		if (stop_mode && ctrl_r[CPWD_C_WDSEL1] && ctrl_r[CPWD_C_STOP_AUTOCLOCK_DISABLE])
			rsync_nxt = CPWD_RESYNC;
		else if (wd_src && rsync_r != 3'h0)
			rsync_nxt = rsync_r - 3'h1;
		wd_cnt_nxt = wd_cnt_r;
		if (wd_svc_r)
			wd_cnt_nxt = '0;
		else if (wd_src && wd_run && rsync_r == 3'h0)
			wd_cnt_nxt = wd_cnt_r + WD_BITS'(1);
		wdr_nxt = wd_fire;
		// follows the status and mask values that land at this same edge
		irq_nxt = |(irqs_nxt & mask_nxt);
		pll_en_nxt = !full_stop;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			osc_stable_r <= 1'b0;
			osc_cnt_r <= 8'h00;
			mon_win_r <= 8'h00;
			mon_edges_r <= 8'h00;
			mon_r <= 1'b0;
			rsync_r <= 3'h0;
			wd_cnt_r <= '0;
			wdr_r <= 1'b0;
			lock_q_r <= 1'b0;
			irq_r <= 1'b0;
			pll_en_r <= 1'b1;
		end
		else
		begin
			osc_stable_r <= osc_stable_nxt;
			osc_cnt_r <= osc_cnt_nxt;
			mon_win_r <= mon_win_nxt;
			mon_edges_r <= mon_edges_nxt;
			mon_r <= mon_nxt;
			rsync_r <= rsync_nxt;
			wd_cnt_r <= wd_cnt_nxt;
			wdr_r <= wdr_nxt;
			lock_q_r <= lock_now;
			irq_r <= irq_nxt;
			pll_en_r <= pll_en_nxt;
		end
	end

	assign hrdata = rd_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign rc_trim = trim_r;
	assign pll_enable = pll_en_r;
	assign ref_range = div_r[16:15];
	assign vco_range = div_r[18:17];
	assign pll_clock = pll_r;
	assign bus_clock_div = bus_r;
	assign monitor_reset = mon_r;
	assign watchdog_reset = wdr_r;
	assign irq = irq_r;
endmodule // cpwd_top

// ---- cpwd_asserts.sv ----
// port-level checker for the clock supervisor top
// sees only cpwd_top ports; bound at the foot of this file
`timescale 1ns/1ns
module cpwd_asserts
	import cpwd_pkg::*;
(
	input wire logic clk, // clock
	input wire logic rstn, // reset, low
	input wire logic [31:0] haddr, // address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write
	input wire logic hsel, // select
	input wire logic [31:0] hrdata, // read data
	input wire logic hreadyout, // slave ready
	input wire logic hresp, // response
	input wire logic [15:0] factory_trim, // flash trim
	input wire logic trim_load_valid, // trim present
	input wire logic stop_mode, // stop request
	input wire logic [15:0] rc_trim, // trim out
	input wire logic pll_enable, // pll on
	input wire logic pll_clock, // divided vco
	input wire logic bus_clock_div, // half of pll clock
	input wire logic monitor_reset, // monitor pulse
	input wire logic watchdog_reset // watchdog pulse
);
	logic loaded_r;
	logic wr;
	assign wr = hsel && htrans[1] && hwrite;
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			loaded_r <= 1'b0;
		else if (trim_load_valid)
			loaded_r <= 1'b1;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_rd_far;
		hsel && htrans[1] && !hwrite &&
			(haddr[9:2] < CPWD_IDX_TRIM_HI || haddr[9:2] > CPWD_IDX_MASK);
	endsequence
	sequence s_full_stop;
		!pll_enable [*3];
	endsequence
	a_ready_high: assert property (hreadyout) else $error("ready dropped");
	a_resp_okay: assert property (!hresp) else $error("error response");
	a_trim_load: assert property (trim_load_valid && !loaded_r |=>
		(rc_trim & 16'hfbff) == ($past(factory_trim) & 16'hfbff)) else $error("trim not loaded");
	a_far_zero: assert property (s_rd_far |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_pll_run: assert property (!stop_mode && !$past(stop_mode) |-> pll_enable)
		else $error("pll off outside stop");
	a_bus_half: assert property ($changed(bus_clock_div) |-> $rose(pll_clock))
		else $error("bus clock not half of pll clock");
	a_stop_quiet: assert property (s_full_stop |-> !monitor_reset)
		else $error("monitor reset in full stop");
	a_mon_pulse: assert property (monitor_reset |=> !monitor_reset)
		else $error("monitor reset too long");
	a_wd_pulse: assert property (watchdog_reset |=> !watchdog_reset)
		else $error("watchdog reset too long");
	a_trim_cause: assert property ($changed(rc_trim) |-> $past(wr) || $past(wr, 2) ||
		$past(wr, 3) || $past(trim_load_valid)) else $error("trim changed uncommanded");
endmodule // cpwd_asserts

bind cpwd_top cpwd_asserts u_chk (.clk(clk), .rstn(rstn), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsel(hsel), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.factory_trim(factory_trim), .trim_load_valid(trim_load_valid), .stop_mode(stop_mode),
	.rc_trim(rc_trim), .pll_enable(pll_enable), .pll_clock(pll_clock),
	.bus_clock_div(bus_clock_div), .monitor_reset(monitor_reset),
	.watchdog_reset(watchdog_reset));

// ---- tb.sv ----
// self-checking bench for cpwd_top over ahb-lite
// rc, xtal and aclk pins are free-running generators, vco is gated by vco_on; watchdog shortened to 16 ticks
`timescale 1ns/1ns
module tb;
	import cpwd_pkg::*;
	logic clk = 0;
	logic rstn = 0;
	logic [31:0] haddr = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] hrdata, r, t;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic hwrite = 0;
	logic hsel = 0;
	logic hreadyout, hresp, pll_enable, pll_clock, bus_clock_div, monitor_reset, watchdog_reset, irq;
	logic [15:0] factory_trim, rc_trim;
	logic [1:0] ref_range, vco_range;
	logic trim_load_valid = 1;
	logic stop_mode = 0;
	logic vco = 0, rc = 0, xo = 0, ac = 0, vco_on = 1;
	int num_errors = 0, samples_checked = 0, mon_n = 0, wd_n = 0, vco_half = 100, m;
	// osc_enable kept set so osc_stable already holds when the crystal case runs
	logic [31:0] cfg [4] = '{32'h0000_0108, 32'h0000_0148, 32'h0000_00b8, 32'h0000_0030};
	logic run [4] = '{1, 0, 1, 0};
	always #10 clk = ~clk;
	always #200 rc = ~rc;
	always #200 xo = ~xo;
	always #300 ac = ~ac;
	always #(vco_half) if (vco_on) vco = ~vco;
	always @(posedge clk) mon_n += monitor_reset;
	always @(posedge clk) wd_n += watchdog_reset;
	cpwd_top #(.WD_BITS(4), .LOCK_WIN(16)) i_dut (.clk(clk), .rstn(rstn), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.factory_trim(factory_trim), .trim_load_valid(trim_load_valid), .vco_clock(vco),
		.ref_src_rc(rc), .crystal_clock(xo), .auto_clock(ac), .stop_mode(stop_mode),
		.rc_trim(rc_trim), .pll_enable(pll_enable), .ref_range(ref_range),
		.vco_range(vco_range), .pll_clock(pll_clock), .bus_clock_div(bus_clock_div),
		.monitor_reset(monitor_reset), .watchdog_reset(watchdog_reset), .irq(irq));
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		haddr <= {22'h0, a, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		hsel <= 1'b1;
		// no wait bound here: only the bench watchdog ends a stalled transfer
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wait_irq();
		for (int k = 0; k < 3000 && irq !== 1'b1; k++)
			@(posedge clk);
		chk("irq_seen", 1, irq);
	endtask
	task automatic print_verdict();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#1_000_000;
		num_errors++;
		$display("CHECK FAILED timeout expected %0d seen %0d", 0, 1);
		print_verdict();
	end
	initial
	begin
		void'($urandom(32'hee907434));
		factory_trim = $urandom;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		trim_load_valid <= 1'b0;
		bus(0, CPWD_IDX_TRIM_HI, 0);
		chk("trim_hi", {24'h0, factory_trim[15:11], 1'b0, factory_trim[9:8]}, r);
		bus(0, CPWD_IDX_TRIM_LO, 0);
		chk("trim_lo", {24'h0, factory_trim[7:0]}, r);
		for (int i = 0; i < 5; i++)
		begin
			t = (i == 0) ? 32'h0000_83ff : (i == 1) ? 32'h0000_0000 : $urandom;
			bus(1, CPWD_IDX_TRIM_HI, {24'h0, t[15:8]});
			bus(1, CPWD_IDX_TRIM_LO, {24'h0, t[7:0]});
			@(negedge clk);
			chk("rc_trim", {16'h0, t[15:0] & 16'hfbff}, {16'h0, rc_trim & 16'hfbff});
			bus(0, CPWD_IDX_TRIM_HI, 0);
			chk("tc_field", {24'h0, t[15:11], 1'b0, t[9:8]}, r);
		end
		bus(1, CPWD_IDX_CTRL, 1);
		bus(1, CPWD_IDX_TRIM_LO, ~t);
		bus(0, CPWD_IDX_TRIM_LO, 0);
		chk("protected", {24'h0, t[7:0]}, r);
		bus(1, CPWD_IDX_CTRL, 0);
		bus(1, 8'hc0, 32'hffff_ffff);
		bus(0, 8'hc0, 0);
		chk("unmapped", 0, r);
		bus(0, CPWD_IDX_DIV, 0);
		chk("div_reset", CPWD_DIV_RST, r);
		t = $urandom;
		bus(1, CPWD_IDX_DIV, {13'h0, t[3:0], 5'h0, 4'h0, 6'h01});
		@(negedge clk);
		chk("ranges", {28'h0, t[3:0]}, {28'h0, vco_range, ref_range});
		bus(1, CPWD_IDX_MASK, 1);
		bus(1, CPWD_IDX_CTRL, 4);
		wait_irq();
		bus(0, CPWD_IDX_STAT, 0);
		chk("lock", 1, r[0]);
		bus(0, CPWD_IDX_IRQ, 0);
		chk("lock_event", 1, r[0]);
		bus(1, CPWD_IDX_IRQ, 7);
		@(negedge clk);
		chk("irq_clear", 0, irq);
		vco_half = 150;
		wait_irq();
		bus(0, CPWD_IDX_STAT, 0);
		chk("unlock", 0, r[0]);
		bus(1, CPWD_IDX_IRQ, 7);
		vco_half = 100;
		bus(1, CPWD_IDX_CTRL, 32'h0000_000a);
		repeat (2000) @(posedge clk);
		bus(0, CPWD_IDX_STAT, 0);
		chk("osc_stable", 3, r & 3);
		bus(1, CPWD_IDX_TRIM_LO, 32'h0000_0055);
		bus(0, CPWD_IDX_STAT, 0);
		chk("stat_cleared", 0, r & 3);
		vco_on = 0;
		m = mon_n;
		repeat (1000) @(posedge clk);
		chk("monitor", 1, mon_n > m);
		stop_mode <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk("pll_off", 0, pll_enable);
		m = mon_n;
		repeat (1000) @(posedge clk);
		chk("monitor_stop", m, mon_n);
		stop_mode <= 1'b0;
		vco_on = 1;
		bus(1, CPWD_IDX_WDSVC, CPWD_WSVC_KEY1);
		bus(1, CPWD_IDX_WDSVC, CPWD_WSVC_KEY2);
		// a pulse launched just before the service must be counted first
		repeat (2) @(posedge clk);
		m = wd_n;
		repeat (6)
		begin
			repeat (100) @(posedge clk);
			bus(1, CPWD_IDX_WDSVC, CPWD_WSVC_KEY1);
			bus(1, CPWD_IDX_WDSVC, CPWD_WSVC_KEY2);
		end
		chk("serviced", m, wd_n);
		repeat (1000) @(posedge clk);
		chk("timeout", 1, wd_n > m);
		for (int i = 0; i < 4; i++)
		begin
			bus(1, CPWD_IDX_CTRL, cfg[i]);
			bus(1, CPWD_IDX_WDSVC, CPWD_WSVC_KEY1);
			bus(1, CPWD_IDX_WDSVC, CPWD_WSVC_KEY2);
			repeat (2) @(posedge clk);
			stop_mode <= 1'b1;
			m = wd_n;
			repeat (1000) @(posedge clk);
			chk("wd_stop", run[i], wd_n > m);
			stop_mode <= 1'b0;
		end
		print_verdict();
	end
endmodule // tb
